// ---- mip_regs.svh ----
// register addresses, field positions, reset values and timing counts
// of the interrupt priority control block.
// assumes the core presents an 8-bit special register address.
`ifndef MIP_REGS_SVH
`define MIP_REGS_SVH

// special register addresses
`define MIP_ADDR_GATES 8'ha8
`define MIP_ADDR_BPRIO 8'hb8
`define MIP_ADDR_ECTRL 8'hd8
`define MIP_ADDR_EGATES 8'he8
`define MIP_ADDR_EPRIO 8'hf8

// field positions
`define MIP_GATES_GLOBAL 7
`define MIP_GATES_UART1 6
`define MIP_GATES_TMR2 5
`define MIP_RSVD_BIT4 4
`define MIP_ECTRL_DOUBLER 7
`define MIP_ECTRL_RSVD_ONE 6
`define MIP_ECTRL_PFAIL 3
`define MIP_EGATES_PFAIL 4

// reserved read patterns and reset values
`define MIP_EXT_RSVD_ONES 3'h7
`define MIP_ECTRL_RSVD_LOW 3'h0
`define MIP_GATES_RESET 8'h00
`define MIP_PRIO_RESET 8'h00
`define MIP_EXT5_RESET 5'h00
`define MIP_UNMAPPED_READ 8'h00

// source count and source indices in polling order
`define MIP_NUM_SRC 11
`define MIP_SRC_PIN0 4'h0
`define MIP_SRC_PIN1 4'h2
`define MIP_SRC_PFAIL 10

// timing: clocks per instruction cycle, least pin hold in clocks
`define MIP_CLK_PER_ICYC 4
`define MIP_PHASE_LAST 2'h3
`define MIP_PIN_HOLD_CLK 3'h4

`endif

// ---- mip_pkg.sv ----
// types of the interrupt priority control block.
// assumes mip_regs.svh supplies the widths used by the consumers.
package mip_pkg;

  // state of one external pin detector
  typedef struct packed {
    logic [2:0] hi_cnt;
    logic [2:0] lo_cnt;
    logic armed;
    logic flag;
    logic lvl;
  } mip_pin_st_t;

  // state of the controller
  typedef struct packed {
    logic [7:0] gates;
    logic [4:0] egates;
    logic [7:0] bprio;
    logic [4:0] eprio;
    logic doubler;
    logic pfail;
    logic [1:0] phase;
    logic [10:0] detect;
    logic wrote_ctl;
    logic [1:0] in_svc;
    logic call;
    logic [3:0] src;
    logic high;
    logic [7:0] rdata;
  } mip_ctl_st_t;

endpackage : mip_pkg

// ---- mip_pin_detect.sv ----
// external interrupt pin detector: falling edge or low level.
// assumes the pin is synchronous to ref_clk_i and active low.
`timescale 1ns/10ps
`include "mip_regs.svh"

module mip_pin_detect (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // pin and mode
  input wire logic pin_n_i,
  input wire logic edge_mode_i,
  // service handshake
  input wire logic clr_i,
  output logic req_o
);

  mip_pkg::mip_pin_st_t st_q;
  mip_pkg::mip_pin_st_t st_d;

  // edge needs a qualified high then a qualified low
  always_comb begin
    st_d = st_q;
    st_d.lvl = ~pin_n_i; // level request held while low
    if (pin_n_i) begin
      st_d.lo_cnt = 3'h0;
      if (st_q.hi_cnt != `MIP_PIN_HOLD_CLK) begin
        st_d.hi_cnt = st_q.hi_cnt + 3'h1;
      end
      if (st_q.hi_cnt + 3'h1 >= `MIP_PIN_HOLD_CLK) begin
        st_d.armed = 1'b1;
      end
    end else begin
      st_d.hi_cnt = 3'h0;
      if (st_q.lo_cnt != `MIP_PIN_HOLD_CLK) begin
        st_d.lo_cnt = st_q.lo_cnt + 3'h1;
      end
    end
    // clear loses against a new edge
    if (clr_i) begin
      st_d.flag = 1'b0;
    end
    if (!pin_n_i && st_q.armed &&
        (st_q.lo_cnt + 3'h1 == `MIP_PIN_HOLD_CLK)) begin
      st_d.flag = 1'b1;
      st_d.armed = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // level mode stays pending while the pin is low
  assign req_o = edge_mode_i ? st_q.flag : st_q.lvl;

endmodule : mip_pin_detect

// ---- mip_irq_ctrl.sv ----
// two-level interrupt priority control for an 8051-style core.
// assumes the core marks each instruction end with instr_end_i, flags
// a return-from-interrupt there, and performs the long call itself
// when vec_call_o pulses; peripheral flags are levels cleared outside.
`timescale 1ns/10ps
`include "mip_regs.svh"

module mip_irq_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // special register port from the core
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_we_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // instruction sequencing from the core
  input wire logic instr_end_i,
  input wire logic instr_reti_i,
  // interrupt sources
  input wire logic [1:0] ext_pin_n_i,
  input wire logic [1:0] pin_edge_mode_i,
  input wire logic timer0_req_i,
  input wire logic timer1_req_i,
  input wire logic timer2_req_i,
  input wire logic uart1_req_i,
  input wire logic [3:0] ext_irq_req_i,
  input wire logic pfail_event_i,
  // vector call to the core
  output logic vec_call_o,
  output logic [3:0] vec_src_o,
  output logic vec_high_o,
  // uart rate control
  output logic uart_rate_doubler_o
);

  mip_pkg::mip_ctl_st_t st_q;
  mip_pkg::mip_ctl_st_t st_d;

  logic [1:0] pin_req;
  logic [1:0] pin_clr;
  logic [10:0] req_vec;
  logic [10:0] gate_vec;
  logic [10:0] prio_vec;
  logic [10:0] pend_vec;
  logic [10:0] live_vec;
  logic [10:0] hi_vec;
  logic [10:0] lo_vec;
  logic pick_hi;
  logic pick_lo;
  logic call_now;
  logic call_pr;
  logic [3:0] call_src;
  logic block_now;
  logic wr_ctl;
  logic [7:0] rd_mux;

  // lowest index wins among equal-level requests
  function automatic logic [3:0] first_src(input logic [10:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 10; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_src

  // one detector per external pin
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      mip_pin_detect u_pin (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_n_i(ext_pin_n_i[g]),
        .edge_mode_i(pin_edge_mode_i[g]),
        .clr_i(pin_clr[g]),
        .req_o(pin_req[g])
      );
    end
  endgenerate

  // source vectors in polling order
  assign req_vec = {st_q.pfail, ext_irq_req_i, timer2_req_i, uart1_req_i,
                    timer1_req_i, pin_req[1], timer0_req_i, pin_req[0]};
  assign gate_vec = {st_q.egates, st_q.gates[`MIP_GATES_TMR2],
                     st_q.gates[`MIP_GATES_UART1], st_q.gates[3:0]};
  assign prio_vec = {st_q.eprio, st_q.bprio[5], st_q.bprio[6],
                     st_q.bprio[3:0]};

  // enabled requests, all held off by the global gate
  assign pend_vec = req_vec & gate_vec &
                    {11{st_q.gates[`MIP_GATES_GLOBAL]}};

  // latched requests still enabled at the boundary
  assign live_vec = st_q.detect & gate_vec &
                    {11{st_q.gates[`MIP_GATES_GLOBAL]}};
  assign hi_vec = live_vec & prio_vec;
  assign lo_vec = live_vec & ~prio_vec;

  // high level first; preempt only a strictly lower level
  assign pick_hi = (|hi_vec) && !st_q.in_svc[1];
  assign pick_lo = !pick_hi && (|lo_vec) && (st_q.in_svc == 2'h0);
  assign call_src = pick_hi ? first_src(hi_vec) : first_src(lo_vec);
  assign call_pr = prio_vec[call_src];

  // writes to gate or priority registers hold off vectoring
  assign wr_ctl = sfr_we_i &&
                  (sfr_addr_i == `MIP_ADDR_GATES ||
                   sfr_addr_i == `MIP_ADDR_EGATES ||
                   sfr_addr_i == `MIP_ADDR_BPRIO ||
                   sfr_addr_i == `MIP_ADDR_EPRIO);
  assign block_now = instr_reti_i || st_q.wrote_ctl || wr_ctl;
  assign call_now = instr_end_i && !block_now && (pick_hi || pick_lo);

  // edge flags of the pins clear when their routine is called
  assign pin_clr[0] = call_now && (call_src == `MIP_SRC_PIN0);
  assign pin_clr[1] = call_now && (call_src == `MIP_SRC_PIN1);

  // read data with reserved bits forced
  always_comb begin
    unique case (sfr_addr_i)
      `MIP_ADDR_GATES: begin
        rd_mux = st_q.gates;
      end
      `MIP_ADDR_EGATES: begin
        rd_mux = {`MIP_EXT_RSVD_ONES, st_q.egates};
      end
      `MIP_ADDR_BPRIO: begin
        rd_mux = {1'b1, st_q.bprio[6:0]};
      end
      `MIP_ADDR_EPRIO: begin
        rd_mux = {`MIP_EXT_RSVD_ONES, st_q.eprio};
      end
      `MIP_ADDR_ECTRL: begin
        rd_mux = {st_q.doubler, 1'b1, 2'h0, st_q.pfail,
                  `MIP_ECTRL_RSVD_LOW};
      end
      default: begin
        rd_mux = `MIP_UNMAPPED_READ;
      end
    endcase
  end

  // next state
  always_comb begin
    st_d = st_q;
    st_d.rdata = rd_mux;
    st_d.phase = st_q.phase + 2'h1;
    st_d.call = call_now;
    // register writes
    if (sfr_we_i) begin
      unique case (sfr_addr_i)
        `MIP_ADDR_GATES: begin
          st_d.gates = sfr_wdata_i;
          st_d.gates[`MIP_RSVD_BIT4] = 1'b0;
        end
        `MIP_ADDR_EGATES: begin
          st_d.egates = sfr_wdata_i[4:0];
        end
        `MIP_ADDR_BPRIO: begin
          st_d.bprio = {1'b0, sfr_wdata_i[6:0]};
          st_d.bprio[`MIP_RSVD_BIT4] = 1'b0;
        end
        `MIP_ADDR_EPRIO: begin
          st_d.eprio = sfr_wdata_i[4:0];
        end
        `MIP_ADDR_ECTRL: begin
          st_d.doubler = sfr_wdata_i[`MIP_ECTRL_DOUBLER];
          st_d.pfail = sfr_wdata_i[`MIP_ECTRL_PFAIL];
        end
        default: begin
          st_d.rdata = rd_mux;
        end
      endcase
    end
    // hardware event wins over a software clear
    if (pfail_event_i) begin
      st_d.pfail = 1'b1;
    end
    // one instruction cycle to detect requests
    if (st_q.phase == `MIP_PHASE_LAST) begin
      st_d.detect = pend_vec;
    end
    // remember a control write until the instruction ends
    if (instr_end_i) begin
      st_d.wrote_ctl = 1'b0;
    end else if (wr_ctl) begin
      st_d.wrote_ctl = 1'b1;
    end
    // return clears the highest marker
    if (instr_end_i && instr_reti_i) begin
      if (st_q.in_svc[1]) begin
        st_d.in_svc[1] = 1'b0;
      end else begin
        st_d.in_svc[0] = 1'b0;
      end
    end
    // vectoring marks the level and retires the request
    if (call_now) begin
      st_d.src = call_src;
      st_d.high = pick_hi;
      st_d.in_svc[pick_hi] = 1'b1;
      st_d.detect[call_src] = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign sfr_rdata_o = st_q.rdata;
  assign vec_call_o = st_q.call;
  assign vec_src_o = st_q.src;
  assign vec_high_o = st_q.high;
  assign uart_rate_doubler_o = st_q.doubler;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic past_call_pr;
  logic past_gate;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      past_call_pr <= 1'b0;
      past_gate <= 1'b0;
    end else begin
      past_call_pr <= call_pr;
      past_gate <= st_q.gates[`MIP_GATES_GLOBAL];
    end
  end

  a_doubler_write: assert property (
    sfr_we_i && sfr_addr_i == `MIP_ADDR_ECTRL
    |=> uart_rate_doubler_o == $past(sfr_wdata_i[7]))
    else $error("rate doubler did not follow write");

  a_pfail_sets: assert property (
    pfail_event_i |=> st_q.pfail ##1 (st_q.rdata[3] ||
      !$past(sfr_addr_i == `MIP_ADDR_ECTRL)))
    else $error("power fail event lost");

  a_pfail_sw_req: assert property (
    sfr_we_i && sfr_addr_i == `MIP_ADDR_ECTRL && sfr_wdata_i[3] &&
    st_q.egates[4] && st_q.gates[7]
    |=> ##[0:4] (st_q.detect[10] || !st_q.pfail || !st_q.egates[4] ||
      !st_q.gates[7] || vec_call_o))
    else $error("software power fail not requested");

  a_rsvd_reads: assert property (
    $past(sfr_addr_i) == `MIP_ADDR_EPRIO |-> sfr_rdata_o[7:5] == 3'h7)
    else $error("reserved priority bits wrong");

  a_ectrl_rsvd: assert property (
    $past(sfr_addr_i) == `MIP_ADDR_ECTRL
    |-> sfr_rdata_o[6] && sfr_rdata_o[2:0] == 3'h0)
    else $error("reserved control bits wrong");

  a_level_match: assert property (
    vec_call_o |-> vec_high_o == past_call_pr)
    else $error("called level differs from priority bit");

  a_low_no_nest: assert property (
    vec_call_o && !vec_high_o |-> $past(st_q.in_svc) == 2'h0)
    else $error("low level call while a routine runs");

  a_high_preempt: assert property (
    vec_call_o && vec_high_o |-> !$past(st_q.in_svc[1]))
    else $error("high level call inside high routine");

  a_skip_reti: assert property (
    instr_end_i && instr_reti_i |=> !vec_call_o)
    else $error("vectored right after return");

  a_gate_off: assert property (
    vec_call_o |-> past_gate)
    else $error("call with global gate off");

  a_mark_set: assert property (
    vec_call_o |-> st_q.in_svc[vec_high_o])
    else $error("in-service marker not set");

  a_reti_clear: assert property (
    instr_end_i && instr_reti_i && st_q.in_svc == 2'h3
    |=> st_q.in_svc == 2'h1)
    else $error("nested return did not resume low routine");

endmodule : mip_irq_ctrl

// ---- mip_core_model.sv ----
// cpu core model: an instruction ends every four clocks, returns on
// request, and stalls instruction ends while a long call runs.
// assumes the same clock and reset as the interrupt controller.
`timescale 1ns/10ps

module mip_core_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // controller side
  input wire logic vec_call_i,
  input wire logic reti_req_i,
  output logic instr_end_o,
  output logic instr_reti_o
);
  logic [1:0] cyc_q;
  logic [4:0] call_q;
  logic reti_q;
  logic fire;

  // an instruction may end only outside a long call
  assign fire = (cyc_q == 2'h2) && (call_q == 5'h00) && !vec_call_i;

  // pacing, long call of four instruction cycles, pending return
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_q <= 2'h0;
      call_q <= 5'h00;
      reti_q <= 1'b0;
      instr_end_o <= 1'b0;
      instr_reti_o <= 1'b0;
    end else begin
      cyc_q <= cyc_q + 2'h1;
      call_q <= vec_call_i ? 5'h10 : call_q - {4'h0, call_q != 5'h00};
      reti_q <= reti_req_i | (reti_q & !fire);
      instr_end_o <= fire;
      instr_reti_o <= fire & reti_q;
    end
  end
endmodule : mip_core_model

// ---- testbench.sv ----
// self-checking bench of the interrupt priority controller.
// assumes the core model paces instructions and takes vector calls.
`timescale 1ns/10ps

module testbench;
  logic ref_clk_i, rst_i, sfr_we_i, vec_call_o, vec_high_o;
  logic instr_end_i, instr_reti_i, reti_req, pfe, uart_rate_doubler_o;
  logic t0, t1, t2, u1;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [1:0] pin_n, edge_mode;
  logic [3:0] ext_req, vec_src_o;
  logic [4:0] exp_q[$];
  int err_total = 0;
  int compares = 0;
  int lat = 0;

  mip_irq_ctrl u_mip_irq_ctrl (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_we_i(sfr_we_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .instr_end_i(instr_end_i), .instr_reti_i(instr_reti_i),
    .ext_pin_n_i(pin_n), .pin_edge_mode_i(edge_mode),
    .timer0_req_i(t0), .timer1_req_i(t1), .timer2_req_i(t2),
    .uart1_req_i(u1), .ext_irq_req_i(ext_req), .pfail_event_i(pfe),
    .vec_call_o(vec_call_o), .vec_src_o(vec_src_o),
    .vec_high_o(vec_high_o), .uart_rate_doubler_o(uart_rate_doubler_o));

  mip_core_model u_mip_core_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .vec_call_i(vec_call_o), .reti_req_i(reti_req),
    .instr_end_o(instr_end_i), .instr_reti_o(instr_reti_i));

  // clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_we_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_we_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    sfr_addr_i <= a;
    repeat (2) @(posedge ref_clk_i);
    check(sfr_rdata_o, want);
  endtask : rd

  // wait for all noted calls, bounded by 200 clocks
  task automatic wait_calls();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    lat = n;
    check(8'(exp_q.size()), 8'h00);
  endtask : wait_calls

  task automatic reti();
    reti_req <= 1'b1;
    @(posedge ref_clk_i);
    reti_req <= 1'b0;
    repeat (24) @(posedge ref_clk_i);
  endtask : reti

  // call monitor: every call must match the oldest noted call
  always @(negedge ref_clk_i) begin
    if (vec_call_o === 1'b1) begin
      if (exp_q.size() == 0)
        check({3'h0, vec_high_o, vec_src_o}, 8'hff);
      else
        check({3'h0, vec_high_o, vec_src_o}, {3'h0, exp_q.pop_front()});
    end
  end

  // watchdog
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] r;
    {rst_i, pin_n} = 3'h7;
    {sfr_we_i, sfr_addr_i, sfr_wdata_i, edge_mode, ext_req} = 23'h0;
    {t0, t1, t2, u1, pfe, reti_req} = 6'h00;
    void'($urandom(32'h6f25));
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    // registers, reserved bits and the rate doubler
    rd(8'hb8, 8'h80);
    rd(8'hf8, 8'he0);
    rd(8'hd8, 8'h40);
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'hef);
    r = 8'($urandom());
    wr(8'hf8, r);
    rd(8'hf8, {3'h7, r[4:0]});
    wr(8'hd8, 8'h87);
    rd(8'hd8, 8'hc0);
    check({7'h0, uart_rate_doubler_o}, 8'h01);
    rd(8'h55, 8'h00);
    $display("test registers done");
    // rank, gating, blocking and nesting
    wr(8'hb8, 8'h08);
    wr(8'hf8, 8'h00);
    t0 <= 1'b1;
    t1 <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    exp_q.push_back({1'b1, 4'h3});
    wr(8'ha8, 8'hca);
    wait_calls();
    t1 <= 1'b0;
    exp_q.push_back({1'b0, 4'h1});
    reti();
    wait_calls();
    t0 <= 1'b0;
    t1 <= 1'b1;
    exp_q.push_back({1'b1, 4'h3});
    wait_calls();
    t1 <= 1'b0;
    u1 <= 1'b1;
    reti();
    repeat (40) @(posedge ref_clk_i);
    exp_q.push_back({1'b0, 4'h4});
    reti();
    wait_calls();
    u1 <= 1'b0;
    reti();
    $display("test priority done");
    // equal level polling order
    wr(8'hb8, 8'h00);
    wr(8'ha8, 8'h0a);
    {t0, t1} <= 2'h3;
    repeat (8) @(posedge ref_clk_i);
    exp_q.push_back({1'b0, 4'h1});
    wr(8'ha8, 8'h8a);
    wait_calls();
    t0 <= 1'b0;
    exp_q.push_back({1'b0, 4'h3});
    reti();
    wait_calls();
    t1 <= 1'b0;
    reti();
    $display("test polling done");
    // power-fail flag by software and by event
    wr(8'he8, 8'h10);
    wr(8'hf8, 8'h10);
    exp_q.push_back({1'b1, 4'ha});
    wr(8'hd8, 8'h08);
    wait_calls();
    wr(8'hd8, 8'h00);
    reti();
    pfe <= 1'b1;
    @(posedge ref_clk_i);
    pfe <= 1'b0;
    exp_q.push_back({1'b1, 4'ha});
    wait_calls();
    check(8'(lat < 52), 8'h01);
    rd(8'hd8, 8'h48);
    wr(8'hd8, 8'h00);
    reti();
    $display("test power fail done");
    // falling edge on pin 0 after a long high
    wr(8'ha8, 8'h81);
    edge_mode <= 2'h1;
    repeat (6) @(posedge ref_clk_i);
    pin_n <= 2'h2;
    exp_q.push_back({1'b0, 4'h0});
    repeat (6) @(posedge ref_clk_i);
    pin_n <= 2'h3;
    wait_calls();
    reti();
    $display("test pin edge done");
    // low level on pin 1 stays requested until called
    wr(8'ha8, 8'h84);
    pin_n <= 2'h1;
    exp_q.push_back({1'b0, 4'h2});
    wait_calls();
    pin_n <= 2'h3;
    reti();
    $display("test pin level done");
    tally_and_finish();
  end
endmodule : testbench
